// File: logic/bcd_card_map.svh
`ifndef BCD_CARD_MAP_SVH
`define BCD_CARD_MAP_SVH

`define REG_IDX_W 6
`define IDX_IDENT_RESET 6'h00
`define IDX_INTR_PTRRST 6'h01
`define IDX_BUSY_START 6'h02
`define IDX_MODE 6'h03
`define IDX_SWITCH_OUTLINES 6'h04
`define IDX_DIGITS_1_2 6'h05
`define IDX_DIGITS_3_4 6'h06
`define IDX_DIGITS_5_6 6'h07
`define IDX_DIGITS_7_8 6'h08
`define IDX_DIGITS_9_10 6'h09
`define IDX_EVENT_STATUS 6'h10
`define IDX_EVENT_MASK 6'h11
`define IDX_INTR_ENABLE 6'h12
`define IDX_XFER_INFO 6'h13

`define INTR_EN_BIT 7
`define INTR_REQ_BIT 6
`define PRIO_LSB 4
`define BUSY_BIT 0
`define EVT_READY_BIT 0
`define EVT_REQ_BIT 1
`define EVT_W 2

`define DIGIT_COUNT 10
`define SWITCH_W 5
`define PTR_W 4

`define CLK_PERIOD_NS 50
`define PRESET_TIME_NS 15000
`define PRESET_CYCLES ((`PRESET_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PRESET_CNT_W 9

`endif

// File: logic/bcd_card_pkg.sv
package bcd_card_pkg;
	typedef enum logic [1:0] {
		HS_IDLE = 2'b00,
		HS_REQ = 2'b01,
		HS_WAIT = 2'b11
	} hs_state_t;
endpackage

// File: logic/bcd_handshake.sv
`timescale 1ns/1ns
module bcd_handshake (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic start_in,
	input wire logic ready_flag_in,
	output logic request_out,
	output logic busy_out,
	output logic done_out
);
	bcd_card_pkg::hs_state_t state_q;
	bcd_card_pkg::hs_state_t state_d;

	always_comb begin
		state_d = state_q;
		case (state_q)
			bcd_card_pkg::HS_IDLE: begin
				if (start_in) begin
					state_d = bcd_card_pkg::HS_REQ;
				end
			end
			// Peripheral must first drop Ready, else a stale flag ends the cycle
			bcd_card_pkg::HS_REQ: begin
				if (!ready_flag_in) begin
					state_d = bcd_card_pkg::HS_WAIT;
				end
			end
			bcd_card_pkg::HS_WAIT: begin
				if (ready_flag_in) begin
					state_d = bcd_card_pkg::HS_IDLE;
				end
			end
			default: begin
				state_d = bcd_card_pkg::HS_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			state_q <= bcd_card_pkg::HS_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			request_out <= 1'b0;
		end else begin
			request_out <= (state_d != bcd_card_pkg::HS_IDLE);
		end
	end

	assign busy_out = (state_q != bcd_card_pkg::HS_IDLE);
	assign done_out = (state_q == bcd_card_pkg::HS_WAIT) && ready_flag_in;
endmodule

// File: logic/bcd_capture.sv
`timescale 1ns/1ns
`include "bcd_card_map.svh"
module bcd_capture (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic capture_in,
	input wire logic [4*`DIGIT_COUNT-1:0] digits_in,
	input wire logic [2:0] sign_overload_line_in,
	output logic [4*`DIGIT_COUNT-1:0] digits_out,
	output logic [2:0] sign_overload_line_out
);
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			digits_out <= '0;
			sign_overload_line_out <= 3'h0;
		end else if (capture_in) begin
			digits_out <= digits_in;
			sign_overload_line_out <= sign_overload_line_in;
		end
	end
endmodule

// File: logic/bcd_card_top.sv
// Contract
// - Status 0 reads a fixed card identity; writes never change it.
// - Non-zero write to control 0 resets the whole interface; zero is ignored.
// - Status 1: bit7 enabled, bit6 request pending, bits5-4 priority, rest zero.
// - Non-zero write to control 1 clears the transfer pointer.
// - Status 2 bit0 is one during a handshake; upper bits zero.
// - Non-zero write to control 2 sets both request lines, starting a handshake; the start is refused here while busy.
// - That same write clears the pending interrupt request.
// - Status 3 reads one in Binary mode, zero in BCD mode.
// - Control 3: non-zero selects Binary, zero selects BCD.
// - Status 4: five option switches in bits7-3, live sign/overload lines in 2-0.
// - Write to control 4 drives eight output lines, bit n to line n.
// - Status 5-9 hold digit pairs, odd digit high nibble, even low.
// - Each handshake latches output data and captures digit, sign, overload inputs.
// - With interrupts enabled, becoming Ready after a handshake raises the request.
//
// Our own choice: the Avalon-MM register port.
`timescale 1ns/1ns
`include "bcd_card_map.svh"
module bcd_card_top #(
	parameter logic [7:0] CARD_ID = 8'h5a // Arbitrary value
) (
	input wire logic REF_CLK_IN,
	input wire logic SYS_RST_IN,
	input wire logic [7:0] ADDRESS_IN,
	input wire logic READ_IN,
	input wire logic WRITE_IN,
	input wire logic [31:0] WRITEDATA_IN,
	input wire logic [3:0] BYTEENABLE_IN,
	output logic [31:0] READDATA_OUT,
	output logic WAITREQUEST_OUT,
	output logic INT_OUT,
	input wire logic [4*`DIGIT_COUNT-1:0] DIGIT_INPUT_BIT_IN,
	input wire logic SIGN_ONE_LINE_IN,
	input wire logic SIGN_TWO_LINE_IN,
	input wire logic OVERLOAD_LINE_IN,
	input wire logic READY_FLAG_IN,
	input wire logic [`SWITCH_W-1:0] OPTION_SWITCHES_IN,
	input wire logic [1:0] PRIORITY_LEVEL_SWITCHES_IN,
	output logic REQUEST_LINE_A_OUT,
	output logic REQUEST_LINE_B_OUT,
	output logic [7:0] DATA_OUT,
	output logic BINARY_MODE_OUT,
	output logic PERIPH_RESET_N_OUT
);
	logic ack_q;
	logic wr_go;
	logic rd_go;
	logic [`REG_IDX_W-1:0] idx;
	logic [7:0] wbyte;
	logic wnz;
	logic iface_rst;
	logic blk_rst;
	logic start_go;
	logic intr_en_q;
	logic intr_req_q;
	logic binary_q;
	logic [7:0] out_data_q;
	logic [`PTR_W-1:0] ptr_q;
	logic [`EVT_W-1:0] evt_q;
	logic [`EVT_W-1:0] evt_d;
	logic [`EVT_W-1:0] evt_set;
	logic [`EVT_W-1:0] mask_q;
	logic [`PRESET_CNT_W-1:0] preset_cnt_q;
	logic hs_req;
	logic hs_busy;
	logic hs_done;
	logic [4*`DIGIT_COUNT-1:0] cap_digits;
	logic [2:0] cap_sign_overload_line;
	logic [7:0] rd_byte;
	logic bus_req;
	logic take;
	logic wr_ident_sel;
	logic wr_ptr_sel;
	logic wr_start_sel;
	logic wr_mode_sel;
	logic wr_out_sel;
	logic wr_en_sel;
	logic wr_evt_sel;
	logic wr_mask_sel;
	logic preset_active;
	logic int_pend;

	localparam logic [`PRESET_CNT_W-1:0] PRESET_LOAD = `PRESET_CNT_W'(`PRESET_CYCLES);

	function automatic logic hit(input logic [`REG_IDX_W-1:0] a, input logic [`REG_IDX_W-1:0] b);
		hit = (a == b);
	endfunction

	// Digit n occupies nibble n-1 of the flat input bus
	function automatic logic [3:0] digit(input logic [4*`DIGIT_COUNT-1:0] d, input int n);
		digit = d[4*(n-1) +: 4];
	endfunction

	// Bus decode: one wait cycle, then a single-cycle answer
	assign idx = ADDRESS_IN[7:2];
	assign wbyte = BYTEENABLE_IN[0] ? WRITEDATA_IN[7:0] : 8'h00;
	assign wnz = (wbyte != 8'h00);
	assign wr_go = WRITE_IN && ack_q && BYTEENABLE_IN[0];
	assign rd_go = READ_IN && !ack_q;
	assign bus_req = READ_IN || WRITE_IN;
	// One take per access; the answer cycle never retakes the held request
	assign take = bus_req && !ack_q;

	// Writes act at the answer edge, while the master still holds its data
	assign wr_ident_sel = wr_go && hit(idx, `IDX_IDENT_RESET);
	assign wr_ptr_sel = wr_go && hit(idx, `IDX_INTR_PTRRST);
	assign wr_start_sel = wr_go && hit(idx, `IDX_BUSY_START);
	assign wr_mode_sel = wr_go && hit(idx, `IDX_MODE);
	assign wr_out_sel = wr_go && hit(idx, `IDX_SWITCH_OUTLINES);
	assign wr_en_sel = wr_go && hit(idx, `IDX_INTR_ENABLE);
	assign wr_evt_sel = wr_go && hit(idx, `IDX_EVENT_STATUS);
	assign wr_mask_sel = wr_go && hit(idx, `IDX_EVENT_MASK);

	assign iface_rst = wr_ident_sel && wnz;
	assign blk_rst = SYS_RST_IN || iface_rst;
	// Starting is refused while busy so a running transfer is not torn
	assign start_go = wr_start_sel && wnz && !hs_busy;

	always_ff @(posedge REF_CLK_IN) begin
		if (SYS_RST_IN) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= take;
		end
	end

	always_ff @(posedge REF_CLK_IN) begin
		if (SYS_RST_IN) begin
			WAITREQUEST_OUT <= 1'b1;
		end else begin
			WAITREQUEST_OUT <= !take;
		end
	end

	always_comb begin
		rd_byte = 8'h00;
		case (idx)
			`IDX_IDENT_RESET: begin
				rd_byte = CARD_ID;
			end
			`IDX_INTR_PTRRST: begin
				rd_byte = {intr_en_q, intr_req_q, PRIORITY_LEVEL_SWITCHES_IN, 4'h0};
			end
			`IDX_BUSY_START: begin
				rd_byte = {7'h00, hs_busy};
			end
			`IDX_MODE: begin
				rd_byte = {7'h00, binary_q};
			end
			`IDX_SWITCH_OUTLINES: begin
				rd_byte = {OPTION_SWITCHES_IN, SIGN_ONE_LINE_IN, SIGN_TWO_LINE_IN,
					OVERLOAD_LINE_IN};
			end
			`IDX_DIGITS_1_2: begin
				rd_byte = {digit(cap_digits, 1), digit(cap_digits, 2)};
			end
			`IDX_DIGITS_3_4: begin
				rd_byte = {digit(cap_digits, 3), digit(cap_digits, 4)};
			end
			`IDX_DIGITS_5_6: begin
				rd_byte = {digit(cap_digits, 5), digit(cap_digits, 6)};
			end
			`IDX_DIGITS_7_8: begin
				rd_byte = {digit(cap_digits, 7), digit(cap_digits, 8)};
			end
			`IDX_DIGITS_9_10: begin
				rd_byte = {digit(cap_digits, 9), digit(cap_digits, 10)};
			end
			`IDX_EVENT_STATUS: begin
				rd_byte = {6'h00, evt_q};
			end
			`IDX_EVENT_MASK: begin
				rd_byte = {6'h00, mask_q};
			end
			`IDX_INTR_ENABLE: begin
				rd_byte = {7'h00, intr_en_q};
			end
			`IDX_XFER_INFO: begin
				rd_byte = {ptr_q, 1'b0, cap_sign_overload_line};
			end
			default: begin
				rd_byte = 8'h00;
			end
		endcase
	end

	// Read data is loaded before the answer cycle and held through it
	always_ff @(posedge REF_CLK_IN) begin
		if (SYS_RST_IN) begin
			READDATA_OUT <= 32'h0000_0000;
		end else if (rd_go) begin
			READDATA_OUT <= {24'h00_0000, rd_byte};
		end
	end

	always_ff @(posedge REF_CLK_IN) begin
		if (blk_rst) begin
			binary_q <= 1'b0;
		end else if (wr_mode_sel) begin
			binary_q <= wnz;
		end
	end

	always_ff @(posedge REF_CLK_IN) begin
		if (blk_rst) begin
			out_data_q <= 8'h00;
		end else if (wr_out_sel) begin
			out_data_q <= wbyte;
		end
	end

	// Lines follow the write at once and are relatched at each request start
	always_ff @(posedge REF_CLK_IN) begin
		if (blk_rst) begin
			DATA_OUT <= 8'h00;
		end else if (wr_out_sel) begin
			DATA_OUT <= wbyte;
		end else if (start_go) begin
			DATA_OUT <= out_data_q;
		end
	end

	always_ff @(posedge REF_CLK_IN) begin
		if (blk_rst) begin
			intr_en_q <= 1'b0;
		end else if (wr_en_sel) begin
			intr_en_q <= wbyte[0];
		end
	end

	// A Ready arriving with the clearing write still wins
	always_ff @(posedge REF_CLK_IN) begin
		if (blk_rst) begin
			intr_req_q <= 1'b0;
		end else if (hs_done && intr_en_q) begin
			intr_req_q <= 1'b1;
		end else if (wr_start_sel && wnz) begin
			intr_req_q <= 1'b0;
		end
	end

	always_ff @(posedge REF_CLK_IN) begin
		if (blk_rst) begin
			ptr_q <= '0;
		end else if (wr_ptr_sel && wnz) begin
			ptr_q <= '0;
		end else if (hs_done) begin
			ptr_q <= ptr_q + `PTR_W'(1);
		end
	end

	assign evt_set = {hs_done && intr_en_q, hs_done};
	assign int_pend = |(evt_q & mask_q);

	// Set is merged after the clear so an event in the clearing cycle is kept
	always_comb begin
		evt_d = evt_q;
		if (wr_evt_sel) begin
			evt_d = evt_q & ~wbyte[`EVT_W-1:0];
		end
		evt_d = evt_d | evt_set;
	end

	always_ff @(posedge REF_CLK_IN) begin
		if (blk_rst) begin
			evt_q <= '0;
		end else begin
			evt_q <= evt_d;
		end
	end

	always_ff @(posedge REF_CLK_IN) begin
		if (blk_rst) begin
			mask_q <= '0;
		end else if (wr_mask_sel) begin
			mask_q <= wbyte[`EVT_W-1:0];
		end
	end

	always_ff @(posedge REF_CLK_IN) begin
		if (blk_rst) begin
			INT_OUT <= 1'b0;
		end else begin
			INT_OUT <= int_pend;
		end
	end

	// Counting down to one, not zero, makes the low time the load value exactly
	assign preset_active = preset_cnt_q > `PRESET_CNT_W'(1);

	// Peripheral reset low for at least the minimum pulse after an interface reset
	always_ff @(posedge REF_CLK_IN) begin
		if (SYS_RST_IN) begin
			preset_cnt_q <= '0;
		end else if (iface_rst) begin
			preset_cnt_q <= PRESET_LOAD;
		end else if (preset_cnt_q != '0) begin
			preset_cnt_q <= preset_cnt_q - `PRESET_CNT_W'(1);
		end
	end

	always_ff @(posedge REF_CLK_IN) begin
		if (SYS_RST_IN) begin
			PERIPH_RESET_N_OUT <= 1'b1;
		end else begin
			PERIPH_RESET_N_OUT <= !(iface_rst || preset_active);
		end
	end

	always_ff @(posedge REF_CLK_IN) begin
		if (SYS_RST_IN) begin
			BINARY_MODE_OUT <= 1'b0;
		end else begin
			BINARY_MODE_OUT <= binary_q;
		end
	end

	// Both request lines share one registered source
	assign REQUEST_LINE_A_OUT = hs_req;
	assign REQUEST_LINE_B_OUT = hs_req;

	bcd_handshake u_handshake (
		.clk_in(REF_CLK_IN),
		.rst_in(blk_rst),
		.start_in(start_go),
		.ready_flag_in(READY_FLAG_IN),
		.request_out(hs_req),
		.busy_out(hs_busy),
		.done_out(hs_done)
	);

	bcd_capture u_capture (
		.clk_in(REF_CLK_IN),
		.rst_in(blk_rst),
		.capture_in(hs_done),
		.digits_in(DIGIT_INPUT_BIT_IN),
		.sign_overload_line_in({SIGN_ONE_LINE_IN, SIGN_TWO_LINE_IN, OVERLOAD_LINE_IN}),
		.digits_out(cap_digits),
		.sign_overload_line_out(cap_sign_overload_line)
	);
endmodule

// File: sim/bcd_card_props.sv
`timescale 1ns/1ns
module bcd_card_props #(
	parameter logic [7:0] CARD_ID = 8'h5a // Arbitrary value
) (
	input wire logic REF_CLK_IN,
	input wire logic SYS_RST_IN,
	input wire logic [7:0] ADDRESS_IN,
	input wire logic READ_IN,
	input wire logic WRITE_IN,
	input wire logic [31:0] WRITEDATA_IN,
	input wire logic [3:0] BYTEENABLE_IN,
	input wire logic [31:0] READDATA_OUT,
	input wire logic WAITREQUEST_OUT,
	input wire logic READY_FLAG_IN,
	input wire logic REQUEST_LINE_A_OUT,
	input wire logic REQUEST_LINE_B_OUT,
	input wire logic [7:0] DATA_OUT,
	input wire logic PERIPH_RESET_N_OUT
);
	default clocking @(posedge REF_CLK_IN); endclocking
	default disable iff (SYS_RST_IN);
	logic rd_ok;
	logic wr_ok;
	logic [5:0] idx;
	assign idx = ADDRESS_IN[7:2];
	assign rd_ok = READ_IN && !WAITREQUEST_OUT;
	assign wr_ok = WRITE_IN && !WAITREQUEST_OUT && BYTEENABLE_IN[0];
	wait_answer_a: assert property ((READ_IN || WRITE_IN) && WAITREQUEST_OUT |=> !WAITREQUEST_OUT)
		else $error("bus answer late");
	wait_pulse_a: assert property (!WAITREQUEST_OUT |=> WAITREQUEST_OUT)
		else $error("answer longer than one cycle");
	ident_read_a: assert property (rd_ok && idx == 6'h00 |-> READDATA_OUT == {24'h0, CARD_ID})
		else $error("identity read wrong");
	intr_low_bits_a: assert property (rd_ok && idx == 6'h01 |-> READDATA_OUT[3:0] == 4'h0)
		else $error("interrupt state low bits set");
	busy_high_bits_a: assert property (rd_ok && idx == 6'h02 |-> READDATA_OUT[7:1] == 7'h0)
		else $error("busy upper bits set");
	req_pair_a: assert property (REQUEST_LINE_A_OUT == REQUEST_LINE_B_OUT)
		else $error("request lines differ");
	start_req_a: assert property (wr_ok && idx == 6'h02 && WRITEDATA_IN[7:0] != 8'h00
		&& !REQUEST_LINE_A_OUT |=> REQUEST_LINE_A_OUT) else $error("start did not set requests");
	ready_done_a: assert property (REQUEST_LINE_A_OUT && $rose(READY_FLAG_IN)
		|=> !REQUEST_LINE_A_OUT) else $error("requests kept after ready");
	data_out_a: assert property (wr_ok && idx == 6'h04
		|=> DATA_OUT == $past(WRITEDATA_IN[7:0])) else $error("data lines wrong");
	iface_reset_a: assert property (wr_ok && idx == 6'h00 && WRITEDATA_IN[7:0] != 8'h00
		|=> (!REQUEST_LINE_A_OUT && DATA_OUT == 8'h00) ##[0:1] !PERIPH_RESET_N_OUT)
		else $error("interface reset incomplete");
	cover property (rd_ok && idx == 6'h05);
	cover property (REQUEST_LINE_A_OUT && $rose(READY_FLAG_IN));
	cover property (wr_ok && idx == 6'h00 && WRITEDATA_IN[7:0] != 8'h00);
endmodule
bind bcd_card_top bcd_card_props #(.CARD_ID(CARD_ID)) u_props (.*);

// File: sim/bcd_periph_model.sv
`timescale 1ns/1ns
module bcd_periph_model (
	input wire logic clk_in,
	input wire logic req_a_in,
	input wire logic req_b_in,
	input wire logic [3:0] lag_in,
	input wire logic [39:0] val_in,
	output logic ready_out,
	output logic [39:0] digits_out
);
	logic [4:0] cnt_q = 5'h0;
	logic done_q = 1'b0;
	initial ready_out = 1'b1;
	initial digits_out = 40'h0;
	always @(posedge clk_in) begin
		// Digits change every cycle outside the capture, no stale value
		digits_out <= ~digits_out;
		if (!(req_a_in && req_b_in)) begin
			done_q <= 1'b0;
			ready_out <= 1'b1;
		end else if (!done_q && cnt_q == 5'h0 && ready_out) begin
			ready_out <= 1'b0;
			cnt_q <= {1'b0, lag_in} + 5'h1;
		end else if (cnt_q == 5'h1) begin
			cnt_q <= 5'h0;
			done_q <= 1'b1;
			ready_out <= 1'b1;
			digits_out <= val_in;
		end else if (cnt_q != 5'h0) begin
			cnt_q <= cnt_q - 5'h1;
		end else if (done_q) begin
			digits_out <= digits_out;
		end
	end
endmodule

// File: sim/bcd_interface_registers_bench.sv
`timescale 1ns/1ns
module bcd_interface_registers_bench;
	localparam logic [7:0] ID = 8'h3c; // Arbitrary value
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic rd_en = 1'b0;
	logic wr_en = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0] be = 4'hf;
	logic [31:0] rdata;
	logic wreq, intr, req_a, req_b, bin, prst_n, ready;
	logic [39:0] digits;
	logic [39:0] val = 40'h0;
	logic [2:0] lines = 3'h0;
	logic [4:0] sw = 5'h0;
	logic [1:0] prio = 2'h0;
	logic [7:0] dout, r;
	logic [3:0] lag = 4'h0;
	int seed = 32'h2c756c4d;
	int failures = 0;
	int checks = 0;
	int hs = 0;
	always #25 clk = ~clk;
	bcd_card_top #(.CARD_ID(ID)) u_dut (.REF_CLK_IN(clk), .SYS_RST_IN(rst), .ADDRESS_IN(addr),
		.READ_IN(rd_en), .WRITE_IN(wr_en), .WRITEDATA_IN(wdata), .BYTEENABLE_IN(be),
		.READDATA_OUT(rdata), .WAITREQUEST_OUT(wreq), .INT_OUT(intr),
		.DIGIT_INPUT_BIT_IN(digits), .SIGN_ONE_LINE_IN(lines[2]), .SIGN_TWO_LINE_IN(lines[1]),
		.OVERLOAD_LINE_IN(lines[0]), .READY_FLAG_IN(ready), .OPTION_SWITCHES_IN(sw),
		.PRIORITY_LEVEL_SWITCHES_IN(prio), .REQUEST_LINE_A_OUT(req_a),
		.REQUEST_LINE_B_OUT(req_b), .DATA_OUT(dout), .BINARY_MODE_OUT(bin),
		.PERIPH_RESET_N_OUT(prst_n));
	bcd_periph_model u_periph (.clk_in(clk), .req_a_in(req_a), .req_b_in(req_b),
		.lag_in(lag), .val_in(val), .ready_out(ready), .digits_out(digits));
	task automatic close_out;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		checks++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %0t got %h want %h", $time, g, e);
		end
	endtask
	task automatic bus(input logic w, input logic [5:0] idx, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk);
		rd_en <= !w;
		wr_en <= w;
		addr <= {idx, 2'b00};
		// Upper data bits random: only the low byte may count
		wdata <= {24'($random(seed)), d};
		do begin
			@(posedge clk);
			n++;
		end while (wreq !== 1'b0 && n < 40);
		if (n >= 40)
			failures++;
		r = rdata[7:0];
		rd_en <= 1'b0;
		wr_en <= 1'b0;
	endtask
	task automatic rc(input logic [5:0] idx, input logic [7:0] e);
		bus(1'b0, idx, 8'h00);
		chk(r, e);
	endtask
	task automatic shake(input logic [3:0] l);
		int n;
		n = 0;
		@(posedge clk);
		lag <= l;
		val <= 40'({$random(seed), $random(seed)});
		lines <= 3'($random(seed));
		sw <= 5'($random(seed));
		prio <= 2'($random(seed));
		bus(1'b1, 6'h02, 8'h01);
		if (l == 4'hf) begin
			rc(6'h01, {2'b10, prio, 4'h0});
			// Start while busy is refused; the running handshake carries on
			bus(1'b1, 6'h02, 8'h01);
			rc(6'h02, 8'h01);
		end
		do begin
			bus(1'b0, 6'h02, 8'h00);
			n++;
		end while (r[0] !== 1'b0 && n < 30);
		if (n >= 30)
			failures++;
		hs++;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		close_out();
	end
	initial begin
		logic [7:0] d;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		rc(6'h00, ID);
		bus(1'b1, 6'h00, 8'h77);
		rc(6'h00, ID);
		bus(1'b1, 6'h03, 8'h40);
		bus(1'b1, 6'h00, 8'h00);
		rc(6'h03, 8'h01);
		chk({7'h0, bin}, 8'h01);
		be <= 4'he;
		bus(1'b1, 6'h03, 8'h00);
		be <= 4'hf;
		rc(6'h03, 8'h01);
		bus(1'b1, 6'h03, 8'h00);
		rc(6'h03, 8'h00);
		rc(6'h3f, 8'h00);
		bus(1'b1, 6'h12, 8'h01);
		bus(1'b1, 6'h11, 8'h03);
		for (int i = 0; i < 6; i++) begin
			d = 8'($random(seed));
			bus(1'b1, 6'h04, d);
			@(negedge clk);
			chk(dout, d);
			shake(i == 0 ? 4'h0 : (i == 1 ? 4'hf : 4'($random(seed))));
			chk(dout, d);
			rc(6'h04, {sw, lines});
			rc(6'h01, {2'b11, prio, 4'h0});
			chk({7'h0, intr}, 8'h01);
			for (int k = 0; k < 5; k++)
				rc(6'h05 + 6'(k), {val[8*k +: 4], val[8*k+4 +: 4]});
			bus(1'b1, 6'h10, 8'h03);
			rc(6'h10, 8'h00);
			chk({7'h0, intr}, 8'h00);
		end
		// Masked: events logged, line stays quiet
		bus(1'b1, 6'h11, 8'h00);
		shake(4'h3);
		chk({7'h0, intr}, 8'h00);
		rc(6'h10, 8'h03);
		bus(1'b1, 6'h12, 8'h00);
		shake(4'h2);
		rc(6'h01, {2'b00, prio, 4'h0});
		rc(6'h13, {4'(hs), 1'b0, lines});
		bus(1'b1, 6'h01, 8'h80);
		rc(6'h13, {4'h0, 1'b0, lines});
		bus(1'b1, 6'h03, 8'h01);
		bus(1'b1, 6'h04, 8'ha5);
		bus(1'b1, 6'h00, 8'h01);
		rc(6'h03, 8'h00);
		chk(dout, 8'h00);
		rc(6'h13, 8'h00);
		close_out();
	end
endmodule
